// ---- design/tcmu_chan_if.sv ----
// Purpose: Carries one channel's signals between the top and the channel
// Assumes: Single clock domain
// Notes: No clocking block
`timescale 1ns/1ps
`default_nettype none
interface tcmu_chan_if;
  logic [15:0] timer_count;
  logic [3:0]  mode;
  logic [15:0] cmp_value;
  logic        ctrl_cleared;
  logic        equal;
  logic        match_evt;
  logic        pin_level;
  logic        pin_oe;
  logic        trig_evt;

  modport top (output timer_count, mode, cmp_value, ctrl_cleared,
               input equal, match_evt, pin_level, pin_oe, trig_evt);
  modport chan (input timer_count, mode, cmp_value, ctrl_cleared,
                output equal, match_evt, pin_level, pin_oe, trig_evt);
endinterface
`default_nettype wire

// ---- design/tcmu_channel.sv ----
// Purpose: One compare channel: equality, match action and output latch
// Assumes: Timer and registers held by the top
// Notes: Outputs are combinational, the top registers them
`timescale 1ns/1ps
`default_nettype none
module tcmu_channel #(
  parameter int CHAN_IDX = 0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Channel signals
  tcmu_chan_if.chan cif
);
  import tcmu_pkg::*;

  logic eq_prev_reg;
  logic eq_prev_next;
  logic latch_reg;
  logic latch_next;

  assign cif.equal = (cif.timer_count == cif.cmp_value);
  // Match counts once when equality begins
  assign cif.match_evt = cif.equal && !eq_prev_reg && tcmu_is_compare(cif.mode);
  assign cif.trig_evt = (CHAN_IDX == TRIG_CHAN) && cif.match_evt && (cif.mode == MODE_TRIG);
  assign cif.pin_oe = tcmu_drives_pin(cif.mode);
  // Pin takes the latch's next value so it moves at the same edge as the flag
  assign cif.pin_level = latch_next;

  // Next state of the latch
  always_comb begin
    eq_prev_next = cif.equal;
    latch_next = latch_reg;
    if (cif.ctrl_cleared) begin
      latch_next = 1'b0;
    end else if (cif.match_evt) begin
      case (cif.mode)
        MODE_TOGGLE: latch_next = ~latch_reg;
        MODE_SET:    latch_next = 1'b1;
        MODE_CLEAR:  latch_next = 1'b0;
        default:     latch_next = latch_reg;
      endcase
    end
  end

  // Register the latch
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      eq_prev_reg <= 1'b0;
      latch_reg <= 1'b0;
    end else begin
      eq_prev_reg <= eq_prev_next;
      latch_reg <= latch_next;
    end
  end

  // Checks on the channel
  chk_toggle_action: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    cif.match_evt && !cif.ctrl_cleared && cif.mode == MODE_TOGGLE
    |=> latch_reg != $past(latch_reg))
    else $error("toggle match did not flip the latch");
  chk_set_clear: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    cif.match_evt && !cif.ctrl_cleared && (cif.mode == MODE_SET || cif.mode == MODE_CLEAR)
    |=> latch_reg == ($past(cif.mode) == MODE_SET))
    else $error("set or clear match gave wrong level");
  chk_zero_ctrl: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    cif.ctrl_cleared |=> !latch_reg)
    else $error("latch not low after control cleared");
  chk_no_pin_swint: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (cif.mode == MODE_SWINT || cif.mode == MODE_TRIG) |-> !cif.pin_oe)
    else $error("pin driven in interrupt or trigger mode");
  chk_trig_fourth: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    cif.trig_evt |-> CHAN_IDX == TRIG_CHAN && cif.timer_count == cif.cmp_value)
    else $error("trigger from wrong channel or without match");
  cov_toggle: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    cif.match_evt && cif.mode == MODE_TOGGLE);
endmodule // tcmu_channel
`default_nettype wire

// ---- design/tcmu_pkg.sv ----
// Purpose: Constants, mode codes and helpers of the timer compare match unit
// Assumes: Word-wide AHB-Lite register map, four compare channels
// Notes: Offsets are byte addresses on the register bus
package tcmu_pkg;

  localparam logic [3:0] MODE_OFF    = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_SET    = 4'h8;
  localparam logic [3:0] MODE_CLEAR  = 4'h9;
  localparam logic [3:0] MODE_SWINT  = 4'hA;
  localparam logic [3:0] MODE_TRIG   = 4'hB;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_BASE = 8'h00;  // Control of channel i at 4*i
  localparam logic [7:0] OFS_CMP_BASE  = 8'h10;  // Low byte at 8*i, high byte 4 above
  localparam logic [7:0] OFS_TMR_LO    = 8'h30;
  localparam logic [7:0] OFS_TMR_HI    = 8'h34;
  localparam logic [7:0] OFS_TCFG      = 8'h38;
  localparam logic [7:0] OFS_FLAGS     = 8'h3C;

  // Field positions
  localparam int TCFG_RUN_BIT = 0;
  localparam int TCFG_EXT_BIT = 1;
  localparam int TCFG_ADC_BIT = 2;
  localparam int FLAG_OVF_BIT = 4;

  // Sizes and counts
  localparam int         NUM_CHAN  = 4;
  localparam int         TRIG_CHAN = 3;
  localparam logic [1:0] DIV_LAST  = 2'h3;  // Instruction clock is sys_clk over four

  // Values after reset
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] CMP_RST  = 16'hFFFF;
  localparam logic [15:0] TMR_RST  = 16'h0000;
  localparam logic [7:0]  TCFG_RST = 8'h00;
  localparam logic [4:0]  FLAG_RST = 5'h00;

  // Mode acts on a match
  function automatic logic tcmu_is_compare(input logic [3:0] mode);
    return (mode == MODE_TOGGLE) || (mode == MODE_SET) || (mode == MODE_CLEAR) ||
           (mode == MODE_SWINT) || (mode == MODE_TRIG);
  endfunction

  // Mode owns the pin
  function automatic logic tcmu_drives_pin(input logic [3:0] mode);
    return (mode == MODE_TOGGLE) || (mode == MODE_SET) || (mode == MODE_CLEAR);
  endfunction

endpackage

// ---- design/timer_compare_match_unit.sv ----
// Purpose: Four compare channels, shared 16-bit timer and AHB-Lite registers
// Assumes: Single word transfers, response always OKAY
// Notes: Reads take one wait state, writes none
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module timer_compare_match_unit (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // External timer clock pin
  input  wire logic        timer_clk_in,
  // Module output pins
  output logic      [3:0]  pin_out,
  output logic      [3:0]  pin_oe_out,
  // Trigger to timer owner and converter
  output logic             special_event_out,
  output logic             adc_start_out
);
  import tcmu_pkg::*;

  // Reset synchroniser
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // Bus state
  logic        wr_pend_reg;
  logic        wr_pend_next;
  logic        rd_pend_reg;
  logic        rd_pend_next;
  logic [7:0]  addr_reg;
  logic [7:0]  addr_next;
  logic [31:0] hrdata_next;
  logic        hready_next;
  logic        accept;

  // Register state
  logic [7:0]  ctrl_reg  [NUM_CHAN];
  logic [7:0]  ctrl_next [NUM_CHAN];
  logic [15:0] cmp_reg   [NUM_CHAN];
  logic [15:0] cmp_next  [NUM_CHAN];
  logic [15:0] tmr_reg;
  logic [15:0] tmr_next;
  logic [7:0]  tcfg_reg;
  logic [7:0]  tcfg_next;
  logic [4:0]  flags_reg;
  logic [4:0]  flags_next;
  logic        pend_reg;
  logic        pend_next;
  logic [1:0]  div_reg;
  logic [1:0]  div_next;

  // Pin synchroniser
  logic        tclk_s1_reg;
  logic        tclk_s2_reg;
  logic        tclk_s3_reg;
  logic        tclk_lvl_reg;

  // Output registers
  logic [3:0]  pin_next;
  logic [3:0]  pin_oe_next;
  logic        sevt_next;
  logic        adc_next;

  // Channel wiring
  logic [NUM_CHAN-1:0] chan_eq;
  logic [NUM_CHAN-1:0] chan_match;
  logic [NUM_CHAN-1:0] chan_lvl;
  logic [NUM_CHAN-1:0] chan_oe;
  logic [NUM_CHAN-1:0] chan_trig;
  logic [NUM_CHAN-1:0] ctrl_zero_wr;
  logic                trig_evt;
  logic                tick;
  logic                tclk_rise;
  logic                wr_en;
  logic                trig_reset;

  tcmu_chan_if cif [NUM_CHAN] ();

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : gen_chan
      assign cif[g].timer_count = tmr_reg;
      assign cif[g].mode = ctrl_reg[g][3:0];
      assign cif[g].cmp_value = cmp_reg[g];
      assign cif[g].ctrl_cleared = ctrl_zero_wr[g];
      assign chan_eq[g] = cif[g].equal;
      assign chan_match[g] = cif[g].match_evt;
      assign chan_lvl[g] = cif[g].pin_level;
      assign chan_oe[g] = cif[g].pin_oe;
      assign chan_trig[g] = cif[g].trig_evt;
      tcmu_channel #(
        .CHAN_IDX (g)
      ) u_chan (
        .clk_in   (sys_clk_in),
        .rst_n_in (rst_n),
        .cif      (cif[g])
      );
    end
  endgenerate

  assign trig_evt = |chan_trig;
  assign wr_en = wr_pend_reg;

  // external timer clock passes three flops
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tclk_s1_reg <= 1'b0;
      tclk_s2_reg <= 1'b0;
      tclk_s3_reg <= 1'b0;
      tclk_lvl_reg <= 1'b0;
    end else begin
      tclk_s1_reg <= timer_clk_in;
      tclk_s2_reg <= tclk_s1_reg;
      tclk_s3_reg <= tclk_s2_reg;
      if (tclk_s2_reg == tclk_s3_reg) begin
        tclk_lvl_reg <= tclk_s2_reg;
      end
    end
  end

  // tick from sys_clk over four or the pin
  assign tclk_rise = (tclk_s2_reg == tclk_s3_reg) && tclk_s2_reg && !tclk_lvl_reg;
  assign tick = tcfg_reg[TCFG_RUN_BIT] &&
                (tcfg_reg[TCFG_EXT_BIT] ? tclk_rise : (div_reg == DIV_LAST));
  // reset only if match still holds
  assign trig_reset = tick && pend_reg && chan_eq[TRIG_CHAN];

  // Bus address phase and read data
  always_comb begin
    accept = hsel_in && hready_in && htrans_in[1];
    wr_pend_next = accept && hwrite_in;
    rd_pend_next = accept && !hwrite_in;
    addr_next = accept ? haddr_in[7:0] : addr_reg;
    hready_next = !(accept && !hwrite_in);
    hrdata_next = hrdata_out;
    if (rd_pend_reg) begin
      hrdata_next = 32'h0000_0000;
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (addr_reg == OFS_CTRL_BASE + 8'(4 * i)) hrdata_next[7:0] = ctrl_reg[i];
        if (addr_reg == OFS_CMP_BASE + 8'(8 * i)) hrdata_next[7:0] = cmp_reg[i][7:0];
        if (addr_reg == OFS_CMP_BASE + 8'(8 * i + 4)) hrdata_next[7:0] = cmp_reg[i][15:8];
      end
      if (addr_reg == OFS_TMR_LO) hrdata_next[7:0] = tmr_reg[7:0];
      if (addr_reg == OFS_TMR_HI) hrdata_next[7:0] = tmr_reg[15:8];
      if (addr_reg == OFS_TCFG) hrdata_next[7:0] = tcfg_reg;
      if (addr_reg == OFS_FLAGS) hrdata_next[4:0] = flags_reg;
    end
  end

  // Register writes, timer and flags
  always_comb begin
    tcfg_next = tcfg_reg;
    div_next = div_reg + 2'h1;
    tmr_next = tmr_reg;
    flags_next = flags_reg;
    pend_next = pend_reg;
    for (int i = 0; i < NUM_CHAN; i++) begin
      ctrl_next[i] = ctrl_reg[i];
      cmp_next[i] = cmp_reg[i];
      ctrl_zero_wr[i] = 1'b0;
      if (wr_en && addr_reg == OFS_CTRL_BASE + 8'(4 * i)) begin
        ctrl_next[i] = hwdata_in[7:0];
        ctrl_zero_wr[i] = (hwdata_in[7:0] == 8'h00);
      end
      if (wr_en && addr_reg == OFS_CMP_BASE + 8'(8 * i)) cmp_next[i][7:0] = hwdata_in[7:0];
      if (wr_en && addr_reg == OFS_CMP_BASE + 8'(8 * i + 4)) cmp_next[i][15:8] = hwdata_in[7:0];
    end
    // Software clears flags by writing one
    if (wr_en && addr_reg == OFS_FLAGS) flags_next = flags_reg & ~hwdata_in[4:0];
    if (wr_en && addr_reg == OFS_TCFG) tcfg_next = hwdata_in[7:0];
    if (trig_reset) begin
      tmr_next = TMR_RST;
    end else if (tick) begin
      tmr_next = tmr_reg + 16'h0001;
      // only a roll over sets overflow
      if (tmr_reg == 16'hFFFF) flags_next[FLAG_OVF_BIT] = 1'b1;
    end
    if (wr_en && addr_reg == OFS_TMR_LO) tmr_next[7:0] = hwdata_in[7:0];
    if (wr_en && addr_reg == OFS_TMR_HI) tmr_next[15:8] = hwdata_in[7:0];
    // flag with the action, set wins over clear
    flags_next[NUM_CHAN-1:0] = flags_next[NUM_CHAN-1:0] | chan_match;
    if (trig_evt) begin
      pend_next = 1'b1;
    end else if (tick) begin
      pend_next = 1'b0;
    end
  end

  // Pin values and enables from channels
  always_comb begin
    pin_next = chan_lvl;
    pin_oe_next = chan_oe;
    sevt_next = trig_evt;
    adc_next = trig_evt && tcfg_reg[TCFG_ADC_BIT];
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      for (int i = 0; i < NUM_CHAN; i++) begin
        ctrl_reg[i] <= CTRL_RST;
        cmp_reg[i] <= CMP_RST;
      end
      tmr_reg <= TMR_RST;
      tcfg_reg <= TCFG_RST;
      flags_reg <= FLAG_RST;
      pend_reg <= 1'b0;
      div_reg <= 2'h0;
      pin_out <= 4'h0;
      pin_oe_out <= 4'h0;
      special_event_out <= 1'b0;
      adc_start_out <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      addr_reg <= addr_next;
      hrdata_out <= hrdata_next;
      hreadyout_out <= hready_next;
      hresp_out <= 1'b0;
      for (int i = 0; i < NUM_CHAN; i++) begin
        ctrl_reg[i] <= ctrl_next[i];
        cmp_reg[i] <= cmp_next[i];
      end
      tmr_reg <= tmr_next;
      tcfg_reg <= tcfg_next;
      flags_reg <= flags_next;
      pend_reg <= pend_next;
      div_reg <= div_next;
      pin_out <= pin_next;
      pin_oe_out <= pin_oe_next;
      special_event_out <= sevt_next;
      adc_start_out <= adc_next;
    end
  end

  // Checks on the top
  chk_flag_with_match: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n)
    chan_match[0] |=> flags_reg[0])
    else $error("match flag not set with action");
  chk_trig_pulse_out: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n)
    trig_evt |=> special_event_out ##1 !special_event_out)
    else $error("trigger output not a one cycle pulse");
  chk_trig_clears_tmr: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n)
    trig_reset && !wr_en |=> tmr_reg == 16'h0000)
    else $error("timer not cleared by trigger");
  chk_no_ovf_on_trig: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n)
    trig_reset && !flags_reg[FLAG_OVF_BIT] |=> !flags_reg[FLAG_OVF_BIT])
    else $error("trigger reset set overflow flag");
  chk_skip_lost_match: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n)
    tick && pend_reg && !chan_eq[TRIG_CHAN] && !wr_en
    |=> tmr_reg == $past(tmr_reg) + 16'h0001)
    else $error("timer reset taken without match");
  chk_adc_gated: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n)
    adc_start_out |-> special_event_out && $past(tcfg_reg[TCFG_ADC_BIT]))
    else $error("conversion start without enabled trigger");
  chk_ovf_on_wrap: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n)
    tick && !trig_reset && tmr_reg == 16'hFFFF |=> flags_reg[FLAG_OVF_BIT])
    else $error("counting wrap did not set overflow flag");
  chk_read_wait: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n)
    rd_pend_reg |-> !hreadyout_out ##1 hreadyout_out)
    else $error("read data phase not one wait state");
  cov_trig_reset: cover property (@(posedge sys_clk_in) disable iff (!rst_n) trig_reset);
  cov_skip: cover property (@(posedge sys_clk_in) disable iff (!rst_n)
    tick && pend_reg && !chan_eq[TRIG_CHAN]);
  cov_overflow: cover property (@(posedge sys_clk_in) disable iff (!rst_n)
    tick && tmr_reg == 16'hFFFF && !trig_reset);
endmodule // timer_compare_match_unit
`default_nettype wire

// ---- testbench/tcmu_timer_partner.sv ----
// Purpose: Far side of the unit: external timer clock source and trigger tally
// Assumes: Driven from the bench clock, changes just after rising edges
// Notes: Timer clock stands low between ticks so no stray count sneaks in
`timescale 1ns/1ps
`default_nettype none
module tcmu_timer_partner (
  // Clock
  input  wire logic clk_in,
  // Timer side
  output logic      timer_clk_out,
  input  wire logic special_event_in,
  input  wire logic adc_start_in,
  // Pulse tallies
  output int        trig_count_out,
  output int        adc_count_out
);
  initial begin
    timer_clk_out  = 1'b0;
    trig_count_out = 0;
    adc_count_out  = 0;
  end

  // slow synchronised tick
  // Wide high and low phases so the three-flop synchroniser sees every edge
  task automatic tick();
    @(posedge clk_in);
    timer_clk_out <= 1'b1;
    repeat (6) @(posedge clk_in);
    timer_clk_out <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask

  // Count cycles where the trigger or conversion start is high
  always @(posedge clk_in) begin
    if (special_event_in === 1'b1) trig_count_out <= trig_count_out + 1;
    if (adc_start_in === 1'b1) adc_count_out <= adc_count_out + 1;
  end
endmodule // tcmu_timer_partner
`default_nettype wire

// ---- testbench/timer_compare_match_unit_test.sv ----
// Purpose: Self-checking bench of the timer compare match unit
// Assumes: Reads take one wait state, writes none, match acts one edge later
// Notes: Random compare values come from an LFSR with a fixed start
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", what, exp, got); end end
module timer_compare_match_unit_test;
  import tcmu_pkg::*;
  logic        sys_clk, rst_n, hsel, hwrite, hreadyout, hresp, timer_clk;
  logic        special_event, adc_start;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  pin, pin_oe, exp_pin;
  logic [15:0] cval;
  int          trig_count, adc_count, miscompares, cmp_count, t0, a0;
  logic [3:0]  modes [6] = '{MODE_SET, MODE_TOGGLE, MODE_CLEAR, MODE_TOGGLE, MODE_TRIG,
                             MODE_SWINT};

  timer_compare_match_unit dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
    .hreadyout_out(hreadyout), .hresp_out(hresp), .timer_clk_in(timer_clk),
    .pin_out(pin), .pin_oe_out(pin_oe), .special_event_out(special_event),
    .adc_start_out(adc_start));

  tcmu_timer_partner partner (.clk_in(sys_clk), .timer_clk_out(timer_clk),
    .special_event_in(special_event), .adc_start_in(adc_start),
    .trig_count_out(trig_count), .adc_count_out(adc_count));

  // Clock of 8 ns
  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;

  // Pseudo-random step
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Latch level expected after a match in mode m
  function automatic logic next_pin(input logic [3:0] m, input logic p);
    return (m == 4'h8) ? 1'b1 : (m == 4'h9) ? 1'b0 : (m == 4'h2) ? ~p : p;
  endfunction

  // One single word transfer; upper address bits are random aliases
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr  <= {seed[31:8], a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel   <= 1'b1;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, {24'h0, d});
  endtask

  task automatic rdr(input logic [7:0] a);
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic set_timer(input logic [15:0] v);
    wr(OFS_TMR_LO, v[7:0]);
    wr(OFS_TMR_HI, v[15:8]);
  endtask

  task automatic set_cmp(input int ch, input logic [15:0] v);
    wr(8'(OFS_CMP_BASE + 8 * ch), v[7:0]);
    wr(8'(OFS_CMP_BASE + 8 * ch + 4), v[15:8]);
  endtask

  task automatic timer_now(output logic [15:0] v);
    rdr(OFS_TMR_LO);
    v[7:0] = rd[7:0];
    rdr(OFS_TMR_HI);
    v[15:8] = rd[7:0];
  endtask

  // Poll the flags until bit b is up, bounded
  task automatic wait_flag(input int b);
    int n;
    n = 0;
    rdr(OFS_FLAGS);
    while (rd[b] !== 1'b1 && n < 40) begin
      rdr(OFS_FLAGS);
      n++;
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog well beyond the roughly one thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    stop_test();
  end

  // Main sequence
  initial begin
    logic [15:0] tv;
    rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; seed = 32'hD53655B8; exp_pin = 4'h0;
    miscompares = 0; cmp_count = 0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Reset values, read back, unmapped place
    for (int ch = 0; ch < 4; ch++) begin
      rdr(8'(OFS_CTRL_BASE + 4 * ch)); `CHK("ctrl reset", CTRL_RST, rd[7:0])
      rdr(8'(OFS_CMP_BASE + 8 * ch)); `CHK("cmp reset", CMP_RST[7:0], rd[7:0])
    end
    rdr(OFS_FLAGS); `CHK("flags reset", 32'h0, rd)
    rdr(8'h40); `CHK("unmapped", 32'h0, rd)
    `CHK("okay response", 1'b0, hresp)
    `CHK("outputs reset", 10'h0, {pin, pin_oe, special_event, adc_start})
    $display("test registers done");
    // Every action code on channels 0 to 2, then a whole-register clear
    for (int ch = 0; ch < 3; ch++) begin
      for (int k = 0; k < 6; k++) begin
        seed = lfsr(seed);
        cval = seed[15:0] | 16'h0010;
        wr(8'(OFS_CTRL_BASE + 4 * ch), 8'h10);
        wr(OFS_TCFG, 8'h00);
        set_timer(cval - 16'h3);
        set_cmp(ch, cval);
        wr(8'(OFS_CTRL_BASE + 4 * ch), {4'h0, modes[k]});
        wr(OFS_FLAGS, 8'h1F);
        t0 = trig_count;
        wr(OFS_TCFG, 8'h01);
        wait_flag(ch);
        wr(OFS_TCFG, 8'h00);
        exp_pin[ch] = next_pin(modes[k], exp_pin[ch]);
        `CHK("match flag", 1'b1, rd[ch])
        // pin level trusted only beside its enable check
        `CHK("pin level", exp_pin[ch], pin[ch])
        `CHK("pin owned", modes[k][3:1] != 3'h5, pin_oe[ch])
        `CHK("no trigger", t0, trig_count)
      end
      wr(8'(OFS_CTRL_BASE + 4 * ch), 8'h00);
      exp_pin[ch] = 1'b0;
      // Latch reaches the pin at the write edge, enable one edge after it
      repeat (2) @(posedge sys_clk);
      `CHK("latch cleared", 2'b00, {pin[ch], pin_oe[ch]})
    end
    $display("test modes done");
    // Overflow flag works when the timer wraps by counting
    set_timer(16'hFFFE);
    wr(OFS_TCFG, 8'h01);
    wait_flag(FLAG_OVF_BIT);
    wr(OFS_TCFG, 8'h00);
    `CHK("overflow flag", 1'b1, rd[FLAG_OVF_BIT])
    // Trigger on the fourth channel, external ticks, conversion enabled
    seed = lfsr(seed);
    cval = seed[15:0] | 16'h0010;
    set_timer(cval - 16'h1);
    set_cmp(TRIG_CHAN, cval);
    wr(8'(OFS_CTRL_BASE + 4 * TRIG_CHAN), {4'h0, MODE_TRIG});
    wr(OFS_FLAGS, 8'h1F);
    t0 = trig_count;
    a0 = adc_count;
    wr(OFS_TCFG, 8'h07);
    partner.tick();
    `CHK("trigger pulse", t0 + 1, trig_count)
    `CHK("adc start", a0 + 1, adc_count)
    `CHK("pin not owned", 1'b0, pin_oe[TRIG_CHAN])
    rdr(OFS_FLAGS); `CHK("trig flag", 1'b1, rd[TRIG_CHAN])
    timer_now(tv); `CHK("timer held", cval, tv)
    partner.tick();
    timer_now(tv); `CHK("timer cleared", 16'h0, tv)
    rdr(OFS_FLAGS); `CHK("no overflow", 1'b0, rd[FLAG_OVF_BIT])
    // Match removed before the next tick, conversion disabled
    wr(OFS_TCFG, 8'h03);
    set_timer(cval - 16'h1);
    partner.tick();
    set_cmp(TRIG_CHAN, cval + 16'h5);
    partner.tick();
    timer_now(tv); `CHK("reset skipped", cval + 16'h1, tv)
    `CHK("second pulse", t0 + 2, trig_count)
    `CHK("adc gated", a0 + 1, adc_count)
    $display("test trigger done");
    stop_test();
  end
endmodule // timer_compare_match_unit_test
`default_nettype wire
